// [core/vsf_cfg.svh]
// Offsets, field positions, reset values and sizes for the slicer FIFO control.
// Assumes an on-chip serial register engine that presents byte-wide accesses.
`ifndef VSF_CFG_SVH
`define VSF_CFG_SVH

`define VSF_A_STATUS    8'hC6
`define VSF_A_WCOUNT    8'hC7
`define VSF_A_THRESH    8'hC8
`define VSF_A_FLUSH     8'hC9
`define VSF_A_LINEIRQ   8'hCA
`define VSF_A_PIXLO     8'hCB
`define VSF_A_PIXHI     8'hCC
`define VSF_A_ROUTE     8'hCD
`define VSF_A_FULLFLD   8'hCF
`define VSF_A_FIFODATA  8'hB0

`define VSF_B_FULLERR   7
`define VSF_B_EMPTY     6
`define VSF_B_F1EN      7
`define VSF_B_F2EN      6

`define VSF_R_THRESH    8'h80
`define VSF_R_LINEIRQ   8'h00
`define VSF_R_PIXLO     8'h4E
`define VSF_R_PIXHI     2'h0
`define VSF_R_ROUTE     1'b1
`define VSF_R_FULLFLD   1'b0
`define VSF_ENTRY_FULL  8'hFF
`define VSF_MIN_LINE    6'h02
`define VSF_WC_MAX      8'hFF
`define VSF_FIFO_BYTES  512

`endif

// [core/vsf_pkg.sv]
// Types shared by the slicer FIFO control and its neighbours.
// Assumes vsf_cfg.svh is available on the include path.
package vsf_pkg;

    // Register access from the serial register engine.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vsf_reg_req_t;

    // Sliced line entering the FIFO: start carries the total byte length.
    typedef struct packed {
        logic       start;
        logic [9:0] len;
        logic       vld;
        logic [7:0] data;
    } vsf_line_t;

    // Video timing of the line being processed.
    typedef struct packed {
        logic [5:0] line_num;
        logic       field2;
        logic       vblank;
        logic [9:0] pixel;
    } vsf_timing_t;

endpackage

// [core/vsf_ctrl.sv]
// Host control and status of the sliced-data FIFO in one decoder channel.
// Assumes the register engine, slicer and timing all run on mclk.
`include "vsf_cfg.svh"

module vsf_ctrl
    import vsf_pkg::*;
#(
    parameter int DEPTH = `VSF_FIFO_BYTES
) (
    // Clock, reset and enable
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    // Register access
    input  wire vsf_reg_req_t reg_req,
    output logic [7:0]        reg_rdata_q,
    output logic              reg_rvalid_q,
    // Slicer data and events
    input  wire vsf_line_t    line_in,
    input  wire logic [5:0]   svc_avail,
    input  wire vsf_timing_t  timing,
    input  wire logic [7:0]   line_entry,
    input  wire logic [7:0]   full_std,
    // Conditions toward the interrupt logic
    output logic              thr_cond_q,
    output logic              line_cond_q,
    // Slicer control
    output logic              std_load_q,
    output logic [7:0]        std_sel_q,
    output logic              slicer_clr_q,
    // Video port
    output logic [7:0]        y_data_q,
    output logic              y_valid_q
);

    localparam int CW = $clog2(DEPTH) + 1;
    localparam int AW = $clog2(DEPTH);
    // The space check is summed wide enough for the longest line, so a long
    // line can never wrap round and seem to fit a small FIFO.
    localparam int NW = ((CW > 10) ? CW : 10) + 2;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    function automatic logic hit(input vsf_reg_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    logic       wr_status, wr_thresh, wr_flush, wr_lineirq;
    logic       wr_pixlo, wr_pixhi, wr_route, wr_fullfld, host_pop;
    assign wr_status  = ce && hit(reg_req, `VSF_A_STATUS);
    assign wr_thresh  = ce && hit(reg_req, `VSF_A_THRESH);
    assign wr_flush   = ce && hit(reg_req, `VSF_A_FLUSH);
    assign wr_lineirq = ce && hit(reg_req, `VSF_A_LINEIRQ);
    assign wr_pixlo   = ce && hit(reg_req, `VSF_A_PIXLO);
    assign wr_pixhi   = ce && hit(reg_req, `VSF_A_PIXHI);
    assign wr_route   = ce && hit(reg_req, `VSF_A_ROUTE);
    assign wr_fullfld = ce && hit(reg_req, `VSF_A_FULLFLD);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0] thresh_q;
    logic [7:0] lineirq_q;
    logic [9:0] switch_pix_q;
    logic       route_host_q;
    logic       fullfld_q;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            thresh_q     <= `VSF_R_THRESH;
            lineirq_q    <= `VSF_R_LINEIRQ;
            switch_pix_q <= {`VSF_R_PIXHI, `VSF_R_PIXLO};
            route_host_q <= `VSF_R_ROUTE;
            fullfld_q    <= `VSF_R_FULLFLD;
        end else begin
            if (wr_thresh)
                thresh_q <= reg_req.wdata;
            if (wr_lineirq)
                lineirq_q <= reg_req.wdata;
            if (wr_pixlo)
                switch_pix_q[7:0] <= reg_req.wdata;
            if (wr_pixhi)
                switch_pix_q[9:8] <= reg_req.wdata[1:0];
            if (wr_route)
                route_host_q <= reg_req.wdata[0];
            if (wr_fullfld)
                fullfld_q <= reg_req.wdata[0];
        end
    end

    // ------------------------------------------------------------------
    // FIFO storage and occupancy
    // ------------------------------------------------------------------
    // Space for a whole line is reserved when it starts, so a host read in
    // mid-line can only widen the margin and a started line completes unless a flush clears it.
    logic [7:0]    mem [DEPTH];
    logic [AW-1:0] wr_ptr_q, rd_ptr_q;
    logic [CW-1:0] cnt_q;
    logic [9:0]    rem_q;
    logic          full_err_q;
    logic          empty, fits, push, pop, y_pop;
    logic [NW-1:0] need;

    assign empty = (cnt_q == '0);
    assign need  = NW'(cnt_q) + NW'(rem_q) + NW'(line_in.len);
    assign fits  = need <= NW'(DEPTH);
    assign push  = ce && !wr_flush && line_in.vld && (rem_q != '0);
    assign host_pop = ce && reg_req.rd && (reg_req.addr == `VSF_A_FIFODATA);
    assign y_pop = ce && !route_host_q && !empty;
    assign pop   = !wr_flush && !empty && (route_host_q ? host_pop : y_pop);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rem_q <= '0;
        end else if (ce) begin
            if (wr_flush)
                rem_q <= '0;
            else if (line_in.start && fits)
                rem_q <= line_in.len;
            else if (push)
                rem_q <= rem_q - 10'd1;
        end
    end

    always_ff @(posedge mclk) begin
        if (push)
            mem[wr_ptr_q] <= line_in.data;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else if (ce) begin
            if (wr_flush) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
                cnt_q    <= '0;
            end else begin
                if (push)
                    wr_ptr_q <= wr_ptr_q + AW'(1);
                if (pop)
                    rd_ptr_q <= rd_ptr_q + AW'(1);
                if (push && !pop)
                    cnt_q <= cnt_q + CW'(1);
                else if (pop && !push)
                    cnt_q <= cnt_q - CW'(1);
            end
        end
    end

    logic [7:0] words;
    always_comb begin
        if ((cnt_q >> 1) > CW'(`VSF_WC_MAX))
            words = `VSF_WC_MAX;
        else
            words = 8'(cnt_q >> 1);
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // A flag event in the same cycle as its write-one clear is kept.
    logic [5:0] avail_q;
    logic [5:0] clr_mask;
    assign clr_mask = wr_status ? reg_req.wdata[5:0] : 6'h00;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            avail_q    <= '0;
            full_err_q <= 1'b0;
        end else if (ce) begin
            if (wr_flush) begin
                avail_q    <= '0;
                full_err_q <= 1'b0;
            end else begin
                avail_q <= (avail_q & ~clr_mask) | svc_avail;
                if (line_in.start && !fits)
                    full_err_q <= 1'b1;
                else if (wr_status && reg_req.wdata[`VSF_B_FULLERR])
                    full_err_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    // The data register pops only while the host owns the FIFO; in video
    // routing it reads as zero so a stray host read cannot steal a byte.
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_req.addr)
            `VSF_A_STATUS:   rd_mux = {full_err_q, empty, avail_q};
            `VSF_A_WCOUNT:   rd_mux = words;
            `VSF_A_THRESH:   rd_mux = thresh_q;
            `VSF_A_LINEIRQ:  rd_mux = lineirq_q;
            `VSF_A_PIXLO:    rd_mux = switch_pix_q[7:0];
            `VSF_A_PIXHI:    rd_mux = {6'h00, switch_pix_q[9:8]};
            `VSF_A_ROUTE:    rd_mux = {7'h00, route_host_q};
            `VSF_A_FULLFLD:  rd_mux = {7'h00, fullfld_q};
            `VSF_A_FIFODATA: rd_mux = (route_host_q && !empty) ? mem[rd_ptr_q] : 8'h00;
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else if (ce) begin
            reg_rvalid_q <= reg_req.rd;
            if (reg_req.rd)
                reg_rdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Video port, conditions and slicer control
    // ------------------------------------------------------------------
    logic line_hit;
    assign line_hit = (timing.line_num == lineirq_q[5:0])
                   && (lineirq_q[5:0] >= `VSF_MIN_LINE)
                   && (timing.field2 ? lineirq_q[`VSF_B_F2EN]
                                     : lineirq_q[`VSF_B_F1EN]);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            y_data_q     <= 8'h00;
            y_valid_q    <= 1'b0;
            thr_cond_q   <= 1'b0;
            line_cond_q  <= 1'b0;
            slicer_clr_q <= 1'b0;
        end else if (ce) begin
            y_valid_q    <= pop && !route_host_q;
            if (pop && !route_host_q)
                y_data_q <= mem[rd_ptr_q];
            thr_cond_q   <= words > thresh_q;
            line_cond_q  <= line_hit;
            slicer_clr_q <= wr_flush;
        end
    end

    // The pixel position must leave the pipeline drained before the switch.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            std_load_q <= 1'b0;
            std_sel_q  <= `VSF_ENTRY_FULL;
        end else if (ce) begin
            std_load_q <= (timing.pixel == switch_pix_q);
            if (timing.pixel == switch_pix_q) begin
                if (fullfld_q && (!timing.vblank || line_entry == `VSF_ENTRY_FULL))
                    std_sel_q <= full_std;
                else
                    std_sel_q <= line_entry;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Low ce holds every register, so each antecedent that expects a change
    // asks for ce except a_route_host and a_low_line; all checks are switched off while reset is low.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_flush_empties: assert property (wr_flush |=> empty && avail_q == '0)
        else $error("flush did not empty the FIFO");
    a_flush_pulse: assert property (wr_flush |=> slicer_clr_q && !full_err_q)
        else $error("flush did not clear the slicer");
    a_misfit_sets: assert property (ce && !wr_flush && line_in.start && !fits
        |=> full_err_q && $stable(wr_ptr_q))
        else $error("misfit line not flagged or written");
    a_misfit_drops: assert property (ce && !wr_flush && line_in.start && !fits
        |=> rem_q == 10'h000)
        else $error("misfit line bytes still accepted");
    a_fit_accepts: assert property (ce && !wr_flush && line_in.start && fits
        && line_in.len != 0 |=> rem_q == $past(line_in.len))
        else $error("fitting line rejected");
    a_empty_flag: assert property (empty |-> rd_ptr_q == wr_ptr_q && words == 8'h00)
        else $error("empty flag disagrees with pointers");
    a_count_push: assert property (push && !pop && !wr_flush
        |=> cnt_q == $past(cnt_q) + CW'(1))
        else $error("push did not raise count");
    a_count_pop: assert property (ce && pop && !push && !wr_flush
        |=> cnt_q == $past(cnt_q) - CW'(1))
        else $error("pop did not lower count");
    a_host_pop: assert property (host_pop && route_host_q && !empty && !wr_flush
        |=> rd_ptr_q == $past(rd_ptr_q) + AW'(1))
        else $error("host read did not advance the FIFO");

    // ------------------------------------------------------------------
    // Checks: flags, conditions, video port and slicer control
    // ------------------------------------------------------------------
    a_read_keeps: assert property (ce && reg_req.rd && !reg_req.wr && avail_q[0]
        && !wr_flush |=> avail_q[0])
        else $error("read cleared a flag");
    a_flag_clear: assert property (wr_status
        |=> (avail_q & $past(reg_req.wdata[5:0]) & ~$past(svc_avail)) == 6'h00)
        else $error("write-one did not clear a flag");
    a_avail_set: assert property (ce && !wr_flush
        |=> (avail_q & $past(svc_avail)) == $past(svc_avail))
        else $error("service event did not set its flag");
    a_thresh_cond: assert property (ce
        |=> thr_cond_q == ($past(words) > $past(thresh_q)))
        else $error("threshold condition wrong");
    a_line_match: assert property (ce && timing.line_num == lineirq_q[5:0]
        && lineirq_q[5:1] != 5'h00 && lineirq_q[`VSF_B_F1EN] && !timing.field2
        |=> line_cond_q)
        else $error("enabled field 1 line match missed");
    a_line_field2: assert property (ce && timing.line_num == lineirq_q[5:0]
        && lineirq_q[5:1] != 5'h00 && lineirq_q[`VSF_B_F2EN] && timing.field2
        |=> line_cond_q)
        else $error("enabled field 2 line match missed");
    a_low_line: assert property (lineirq_q[5:1] == 5'h00 |=> !line_cond_q)
        else $error("line zero or one raised a condition");
    a_switch_load: assert property (ce && timing.pixel == switch_pix_q
        |=> std_load_q)
        else $error("no load at switch pixel");
    a_route_host: assert property (route_host_q |=> !y_valid_q)
        else $error("video port driven in host mode");
    a_route_video: assert property (ce && !route_host_q && !empty && !wr_flush
        |=> y_valid_q)
        else $error("video port did not drain the FIFO");
    a_full_std: assert property (ce && timing.pixel == switch_pix_q && fullfld_q
        && !timing.vblank |=> std_sel_q == $past(full_std))
        else $error("full field standard not chosen");
    a_entry_wins: assert property (ce && timing.pixel == switch_pix_q
        && line_entry != `VSF_ENTRY_FULL && timing.vblank
        |=> std_sel_q == $past(line_entry))
        else $error("line entry did not override");
    a_fullfld_write: assert property (wr_fullfld
        |=> fullfld_q == $past(reg_req.wdata[0]))
        else $error("full field enable not written");

    c_full_err: cover property (line_in.start && !fits ##1 full_err_q);
    c_host_read: cover property (host_pop && !empty);
    c_line_hit: cover property (line_cond_q);
    c_full_std: cover property (std_load_q && fullfld_q);
    c_video_out: cover property (y_valid_q);

endmodule // vsf_ctrl

// [verif/vsf_src.sv]
// Sliced-line source standing where the slicer feeds the FIFO control.
// Assumes the bench starts a line only after the previous one has finished.
module vsf_src
    import vsf_pkg::*;
(
    // Clock
    input  wire logic mclk,
    // Sliced line toward the FIFO control
    output vsf_line_t sliced
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sliced = '0;
    end

    // Bytes follow the start pulse one per cycle.
    // The data line flips after the last byte so that a stale byte is never mistaken for fresh.
    task automatic send(input logic [9:0] len, input logic [7:0] base);
        @(posedge mclk);
        #1 sliced.start = 1'b1;
        sliced.len = len;
        for (int i = 0; i < len; i++) begin
            @(posedge mclk);
            #1 sliced.start = 1'b0;
            sliced.vld = 1'b1;
            sliced.data = base + 8'(i);
        end
        @(posedge mclk);
        #1 sliced.vld = 1'b0;
        sliced.data = ~sliced.data;
    endtask
endmodule // vsf_src

// [verif/vbi_slicer_fifo_status_control_test.sv]
// Self-checking bench for the sliced-data FIFO control.
// Assumes a 16-byte FIFO so that the full case is reached with short lines.
module vbi_slicer_fifo_status_control_test
    import vsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic         mclk = 1'b0;
    logic         rst_b = 1'b0;
    logic         ce = 1'b1;
    vsf_reg_req_t req = '0;
    vsf_line_t    sliced;
    logic [5:0]   svc = '0;
    vsf_timing_t  tim = '0;
    logic [7:0]   entry = 8'hFF;
    logic [7:0]   fstd = 8'h3C;
    logic [7:0]   rdata, ydata, sel;
    logic         rvalid, yvalid, thr, lcond, ld, clr;
    logic [7:0]   rq[$], yq[$], mq[$];
    logic [16:0]  lf = 17'd68248;
    bit           to_y = 1'b0;
    int           errors = 0;
    int           n_compared = 0;

    localparam logic [7:0] RA [9] = '{8'hC6, 8'hC7, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
                                      8'hCF, 8'hC0};
    localparam logic [7:0] RV [9] = '{8'h40, 8'h00, 8'h80, 8'h00, 8'h4E, 8'h00, 8'h01,
                                      8'h00, 8'h00};
    localparam logic [15:0] LT [6] = '{{8'h85, 6'd5, 2'b01}, {8'h85, 6'd5, 2'b10},
                                       {8'h45, 6'd5, 2'b11}, {8'hC1, 6'd1, 2'b00},
                                       {8'hC0, 6'd0, 2'b10}, {8'hC2, 6'd2, 2'b11}};
    localparam logic [17:0] ST [4] = '{{2'b00, 8'h12, 8'h12}, {2'b10, 8'h12, 8'h3C},
                                       {2'b11, 8'hFF, 8'h3C}, {2'b11, 8'h12, 8'h12}};

    initial begin
        forever #20 mclk = ~mclk;
    end

    vsf_ctrl #(.DEPTH(16)) u_vsf_ctrl (
        .mclk(mclk), .rst_b(rst_b), .ce(ce), .reg_req(req), .reg_rdata_q(rdata),
        .reg_rvalid_q(rvalid), .line_in(sliced), .svc_avail(svc), .timing(tim),
        .line_entry(entry), .full_std(fstd), .thr_cond_q(thr), .line_cond_q(lcond),
        .std_load_q(ld), .std_sel_q(sel), .slicer_clr_q(clr), .y_data_q(ydata),
        .y_valid_q(yvalid));

    vsf_src u_vsf_src (.mclk(mclk), .sliced(sliced));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [16:0] lfsr_next(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Counts: %0d compared, %0d mismatched", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge mclk);
        #1 req.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        @(posedge mclk);
        #1 req.rd = 1'b1;
        req.addr = a;
        @(posedge mclk);
        #1 req.rd = 1'b0;
        @(posedge mclk);
    endtask

    // A refused line leaves no note, since none of its bytes may come back.
    task automatic send_line(input logic [9:0] len, input bit keep);
        logic [7:0] b;
        lf = lfsr_next(lf);
        b = lf[7:0];
        for (int i = 0; i < len; i++) begin
            if (keep && to_y) yq.push_back(b + 8'(i));
            else if (keep) mq.push_back(b + 8'(i));
        end
        u_vsf_src.send(len, b);
        repeat (2) @(posedge mclk);
    endtask

    task automatic done(input string nm);
        $display("Test %s finished", nm);
    endtask

    always @(negedge mclk) begin
        if (rvalid === 1'b1) chk("rdata", rdata, rq.pop_front());
        if (yvalid === 1'b1) chk("ydata", ydata, yq.pop_front());
    end

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        close_out();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        #1 rst_b = 1'b1;
        ce = 1'b0;
        wr(8'hC8, 8'h11);
        ce = 1'b1;
        for (int k = 0; k < 9; k++) rd(RA[k], RV[k]);
        done("reset");
        send_line(10'd6, 1'b1);
        rd(8'hC7, 8'h03);
        rd(8'hC6, 8'h00);
        wr(8'hC8, 8'h02);
        settle();
        chk("thr", {7'h0, thr}, 8'h01);
        wr(8'hC8, 8'h03);
        settle();
        chk("thr", {7'h0, thr}, 8'h00);
        send_line(10'd12, 1'b0);
        rd(8'hC6, 8'h80);
        rd(8'hC7, 8'h03);
        send_line(10'd4, 1'b1);
        rd(8'hC7, 8'h05);
        rd(8'hC6, 8'h80);
        rd(8'hB0, mq.pop_front());
        rd(8'hB0, mq.pop_front());
        rd(8'hC7, 8'h04);
        while (mq.size() > 0) rd(8'hB0, mq.pop_front());
        rd(8'hC6, 8'hC0);
        wr(8'hC6, 8'h80);
        rd(8'hC6, 8'h40);
        done("fifo");
        @(posedge mclk);
        #1 svc = 6'h2A;
        @(posedge mclk);
        #1 svc = 6'h00;
        rd(8'hC6, 8'h6A);
        rd(8'hC6, 8'h6A);
        wr(8'hC6, 8'h02);
        rd(8'hC6, 8'h68);
        #1 svc = 6'h15;
        @(posedge mclk);
        #1 svc = 6'h00;
        rd(8'hC6, 8'h7D);
        send_line(10'd4, 1'b0);
        wr(8'hC9, lf[7:0]);
        chk("clr", {7'h0, clr}, 8'h01);
        rd(8'hC6, 8'h40);
        rd(8'hC7, 8'h00);
        done("flags");
        wr(8'hCD, 8'h00);
        to_y = 1'b1;
        send_line(10'd6, 1'b1);
        to_y = 1'b0;
        for (int k = 0; k < 20 && yq.size() > 0; k++) @(posedge mclk);
        if (yq.size() > 0) begin
            errors++;
            close_out();
        end
        rd(8'hB0, 8'h00);
        wr(8'hCD, 8'h01);
        done("route");
        for (int k = 0; k < 6; k++) begin
            wr(8'hCA, LT[k][15:8]);
            tim.line_num = LT[k][7:2];
            tim.field2 = LT[k][1];
            settle();
            chk("lcond", {7'h0, lcond}, {7'h0, LT[k][0]});
        end
        done("line");
        wr(8'hCB, 8'h05);
        wr(8'hCC, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(8'hCF, {7'h0, ST[k][17]});
            tim.vblank = ST[k][16];
            entry = ST[k][15:8];
            @(posedge mclk);
            #1 tim.pixel = 10'h005;
            @(posedge mclk);
            #1 chk("load", {7'h0, ld}, 8'h00);
            tim.pixel = 10'h105;
            @(posedge mclk);
            #1 chk("load", {7'h0, ld}, 8'h01);
            chk("sel", sel, ST[k][7:0]);
            tim.pixel = 10'h000;
        end
        done("switch");
        @(posedge mclk);
        #1 rst_b = 1'b0;
        repeat (2) @(posedge mclk);
        #1 rst_b = 1'b1;
        rd(8'hC8, 8'h80);
        rd(8'hCB, 8'h4E);
        rd(8'hCF, 8'h00);
        rd(8'hC6, 8'h40);
        done("rerun");
        close_out();
    end
endmodule // vbi_slicer_fifo_status_control_test
